//--- rtl/dir_defs.svh
// offsets, fields, reset values and timing counts of the clock mode / fs detect block
// assumes a 10 MHz sys_clk and a reference tick of fref/512 from the clock generator
`ifndef DIR_DEFS_SVH
`define DIR_DEFS_SVH
`define SYS_CLK_PERIOD_NS   100
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_IRQ_STAT        8'h08
`define REG_IRQ_MASK        8'h0c
`define CTRL_RESET          6'h00
`define MODE_PLL            2'h0
`define MODE_EXT            2'h1
`define MODE_AUTO           2'h2
`define MODE_EXT_MON        2'h3
`define REF_USE_CS          2'h3
`define RATE_44K1           4'h0
`define RATE_RSVD           4'h1
`define RATE_48K            4'h2
`define RATE_32K            4'h3
`define RATE_88K2           4'h8
`define RATE_96K            4'ha
`define RATE_176K4          4'hc
`define RATE_192K           4'he
`define RATE_RESET          4'h1
// lock range and qualification
`define FRAME_MIN_NS        5000
`define FRAME_MAX_NS        33000
`define FRAME_MIN_CYC       (`FRAME_MIN_NS / `SYS_CLK_PERIOD_NS)
`define FRAME_MAX_CYC       (`FRAME_MAX_NS / `SYS_CLK_PERIOD_NS)
`define FRAME_JITTER_CYC    2
`define LOCK_TIME_US        20000
`define LOCK_QUAL_US        10000
`define LOCK_QUAL_CYCLES_DEF (`LOCK_QUAL_US * 1000 / `SYS_CLK_PERIOD_NS)
// rate comparison: window in ref ticks, k = fref / 1600 Hz
`define RATE_WIN_TICKS      512
`define RATE_WIN_TICKS_384  768
`define REF_K_11M2896       15'd7056
`define REF_K_12M288        15'd7680
`define REF_K_24M576        15'd15360
// frames * k; 163840 per kHz, midpoints between nominal rates, far limits at 24 and 240 kHz
`define THR_FAR_LOW         28'd3932160
`define THR_32_44           28'd6234112
`define THR_44_48           28'd7544832
`define THR_48_88           28'd11157504
`define THR_88_96           28'd15089664
`define THR_96_176          28'd22315008
`define THR_176_192         28'd30179328
`define THR_FAR_HIGH        28'd39321600
`endif

//--- rtl/dir_pkg.sv
// types shared by the clock mode / fs detect block
// constants live in dir_defs.svh
package dir_pkg;
    typedef struct packed {
        logic [7:0] byte4;
        logic [7:0] byte3;
        logic [7:0] byte0;
    } cs_block_s;
    typedef struct packed {
        logic       status_channel_select;
        logic       ref_freq_sel_hi;
        logic       ref_freq_sel_lo;
        logic       ref_ratio_select;
        logic       clock_mode_sel_hi;
        logic       clock_mode_sel_lo;
    } ctrl_s;
    typedef struct packed {
        logic       pll_run;
        logic       external_clock_path;
        logic       serial_data_out_from_transmitter;
    } clk_route_s;
    typedef enum logic [1:0] {LK_HUNT, LK_QUALIFY, LK_LOCKED} lock_state_e;
endpackage

//--- rtl/rate_meter.sv
// clock comparison rate meter: frames counted over a window of reference ticks
// assumes both ticks are one-cycle pulses already in the sys_clk domain
`timescale 1ns/100ps
`include "dir_defs.svh"
module rate_meter #(
    parameter int CW = 13
)(
    // clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // ticks
    input  wire logic       ref_tick,
    input  wire logic       frame_tick,
    // settings
    input  wire logic       run,
    input  wire logic       ref_ratio,
    input  wire logic [1:0] ref_sel,
    // result
    output logic      [3:0] code_out,
    output logic            code_valid
);
    logic [9:0]    tick_reg, tick_next;
    logic [CW-1:0] frm_reg, frm_next;
    logic [3:0]    code_next;
    logic          valid_next;
    logic [14:0]   k;
    logic [27:0]   prod;
    logic [9:0]    win_last;

    always_comb begin
        // 384fs reference: 1.5x the ticks gives the same window time
        win_last = ref_ratio ? 10'(`RATE_WIN_TICKS_384 - 1)
                             : 10'(`RATE_WIN_TICKS - 1);
        case (ref_sel)
            2'h1:    k = `REF_K_12M288;
            2'h2:    k = `REF_K_24M576;
            default: k = `REF_K_11M2896;
        endcase
        prod = 28'(frm_reg) * 28'(k);
        tick_next = tick_reg;
        frm_next = frm_reg;
        code_next = code_out;
        valid_next = 1'b0;
        if (frame_tick && frm_reg != {CW{1'b1}})
            frm_next = frm_reg + 1'b1;
        if (!run) begin
            tick_next = '0;
            frm_next = '0;
        end else if (ref_tick) begin
            tick_next = tick_reg + 1'b1;
            if (tick_reg == win_last) begin
                tick_next = '0;
                frm_next = '0;
                valid_next = 1'b1;
                // nearest nominal rate, far out of range reads reserved
                if (prod < `THR_FAR_LOW)       code_next = `RATE_RSVD;
                else if (prod < `THR_32_44)    code_next = `RATE_32K;
                else if (prod < `THR_44_48)    code_next = `RATE_44K1;
                else if (prod < `THR_48_88)    code_next = `RATE_48K;
                else if (prod < `THR_88_96)    code_next = `RATE_88K2;
                else if (prod < `THR_96_176)   code_next = `RATE_96K;
                else if (prod < `THR_176_192)  code_next = `RATE_176K4;
                else if (prod < `THR_FAR_HIGH) code_next = `RATE_192K;
                else                           code_next = `RATE_RSVD;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tick_reg   <= '0;
            frm_reg    <= '0;
            code_out   <= `RATE_RESET;
            code_valid <= 1'b0;
        end else if (ce) begin
            tick_reg   <= tick_next;
            frm_reg    <= frm_next;
            code_out   <= code_next;
            code_valid <= valid_next;
        end
    end
endmodule

//--- rtl/dir_clock_mode_fs_detect.sv
// receiver clock mode select, lock tracking, fs and pre-emphasis detection, ahb-lite regs
// assumes preamble and reference tick pins are asynchronous; channel status on sys_clk
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "dir_defs.svh"
module dir_clock_mode_fs_detect
    import dir_pkg::*;
#(
    parameter int LOCK_QUAL_CYCLES = `LOCK_QUAL_CYCLES_DEF
)(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // receiver side
    input  wire logic        preamble_in,
    input  wire logic        ref_tick_in,
    input  wire logic        cs_update,
    input  wire cs_block_s   cs_ch1,
    input  wire cs_block_s   cs_ch2,
    // clock routing and status
    output clk_route_s       route,
    output logic             unlock,
    output logic [3:0]       detected_rate_code,
    output logic             preemphasis_flag,
    output logic             irq
);
    localparam int QW = $clog2(LOCK_QUAL_CYCLES + 1);

    // pin synchronisers: bit 0 preamble, bit 1 reference tick
    logic [1:0] s1_reg, s2_reg, s3_reg;
    logic       pre_tick, ref_tick;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else if (ce) begin
            s1_reg <= {ref_tick_in, preamble_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_comb begin
        pre_tick = s2_reg[0] & ~s3_reg[0];
        ref_tick = s2_reg[1] & ~s3_reg[1];
    end

    // register state
    ctrl_s       ctrl_reg, ctrl_next;
    logic [3:0]  mask_reg, mask_next;
    logic [3:0]  stat_reg, stat_next;
    logic        irq_next;
    logic        ph_wr_reg, ph_wr_next;
    logic [7:0]  ph_addr_reg, ph_addr_next;
    logic [31:0] hrdata_next;
    logic        stat_rd;
    logic [1:0]  mode;
    logic [1:0]  ref_sel;

    // lock state
    lock_state_e lk_reg, lk_next;
    logic [8:0]  ivl_reg, ivl_next;
    logic [8:0]  prev_reg, prev_next;
    logic [QW-1:0] qual_reg, qual_next;
    logic        ivl_ok, steady;
    logic [8:0]  diff;

    // detection state
    clk_route_s  route_next;
    logic        unlock_next;
    logic [3:0]  rate_next;
    logic        pem_next;
    logic        pro_reg, pro_next;
    cs_block_s   cs_sel;
    logic [3:0]  cs_rate;
    logic        cs_pem;
    logic [3:0]  meter_code;
    logic        meter_valid;
    logic [3:0]  events;

    always_comb begin
        mode    = {ctrl_reg.clock_mode_sel_hi, ctrl_reg.clock_mode_sel_lo};
        ref_sel = {ctrl_reg.ref_freq_sel_hi, ctrl_reg.ref_freq_sel_lo};
    end

    // lock tracking on preamble spacing
    always_comb begin
        ivl_next  = (ivl_reg == 9'h1ff) ? ivl_reg : ivl_reg + 1'b1;
        prev_next = prev_reg;
        lk_next   = lk_reg;
        qual_next = qual_reg;
        diff   = (ivl_reg > prev_reg) ? ivl_reg - prev_reg : prev_reg - ivl_reg;
        ivl_ok = ivl_reg >= 9'(`FRAME_MIN_CYC) && ivl_reg <= 9'(`FRAME_MAX_CYC);
        steady = ivl_ok && diff <= 9'(`FRAME_JITTER_CYC);
        if (lk_reg == LK_QUALIFY)
            qual_next = qual_reg + 1'b1;
        if (pre_tick) begin
            ivl_next  = 9'h001;
            prev_next = ivl_reg;
            case (lk_reg)
                LK_HUNT: begin
                    if (ivl_ok) begin
                        lk_next   = LK_QUALIFY;
                        qual_next = '0;
                    end
                end
                LK_QUALIFY, LK_LOCKED: begin
                    if (!steady)
                        lk_next = LK_HUNT;
                end
                default: lk_next = LK_HUNT;
            endcase
        end else if (ivl_reg > 9'(`FRAME_MAX_CYC)) begin
            lk_next = LK_HUNT;
        end
        if (lk_reg == LK_QUALIFY && lk_next == LK_QUALIFY
                && qual_reg == QW'(LOCK_QUAL_CYCLES - 1))
            lk_next = LK_LOCKED;
        if (!route.pll_run)
            lk_next = LK_HUNT;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lk_reg   <= LK_HUNT;
            ivl_reg  <= '0;
            prev_reg <= '0;
            qual_reg <= '0;
        end else if (ce) begin
            lk_reg   <= lk_next;
            ivl_reg  <= ivl_next;
            prev_reg <= prev_next;
            qual_reg <= qual_next;
        end
    end

    rate_meter #(
        .CW (13)
    ) u_meter (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .ce         (ce),
        .ref_tick   (ref_tick),
        .frame_tick (pre_tick),
        .run        (lk_reg == LK_LOCKED && ref_sel != `REF_USE_CS),
        .ref_ratio  (ctrl_reg.ref_ratio_select),
        .ref_sel    (ref_sel),
        .code_out   (meter_code),
        .code_valid (meter_valid)
    );

    // channel status decode
    always_comb begin
        cs_sel = ctrl_reg.status_channel_select ? cs_ch2 : cs_ch1;
        cs_rate = `RATE_RSVD;
        if (!cs_sel.byte0[0]) begin
            cs_rate = cs_sel.byte3[3:0];
            cs_pem = !cs_sel.byte0[1] && cs_sel.byte0[3]
                     && !cs_sel.byte0[4] && !cs_sel.byte0[5];
        end else begin
            cs_pem = cs_sel.byte0[2] && cs_sel.byte0[3] && !cs_sel.byte0[4];
            case ({cs_sel.byte0[7:6], cs_sel.byte4[6:3]})
                6'h10:   cs_rate = `RATE_44K1;
                6'h20:   cs_rate = `RATE_48K;
                6'h30:   cs_rate = `RATE_32K;
                6'h0a:   cs_rate = `RATE_88K2;
                6'h02:   cs_rate = `RATE_96K;
                6'h0b:   cs_rate = `RATE_176K4;
                6'h03:   cs_rate = `RATE_192K;
                default: cs_rate = `RATE_RSVD;
            endcase
        end
    end

    // clock routing and detected values
    always_comb begin
        unlock_next = lk_next != LK_LOCKED;
        case (mode)
            `MODE_PLL:  route_next = 3'b100;
            `MODE_EXT:  route_next = 3'b011;
            `MODE_AUTO: route_next = {1'b1, unlock_next, unlock_next};
            default:    route_next = 3'b111;
        endcase
        rate_next = detected_rate_code;
        pem_next  = preemphasis_flag;
        pro_next  = pro_reg;
        if (cs_update) begin
            pem_next = cs_pem;
            pro_next = cs_sel.byte0[0];
            if (ref_sel == `REF_USE_CS)
                rate_next = cs_rate;
        end
        if (meter_valid && ref_sel != `REF_USE_CS)
            rate_next = meter_code;
        events = {pem_next != preemphasis_flag, rate_next != detected_rate_code,
                  unlock && !unlock_next, !unlock && unlock_next};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            route              <= 3'b100;
            unlock             <= 1'b1;
            detected_rate_code <= `RATE_RESET;
            preemphasis_flag   <= 1'b0;
            pro_reg            <= 1'b0;
        end else if (ce) begin
            route              <= route_next;
            unlock             <= unlock_next;
            detected_rate_code <= rate_next;
            preemphasis_flag   <= pem_next;
            pro_reg            <= pro_next;
        end
    end

    // ahb-lite slave, zero wait states; reads answered from the address phase
    always_comb begin
        ph_wr_next   = 1'b0;
        ph_addr_next = ph_addr_reg;
        hrdata_next  = hrdata;
        ctrl_next    = ctrl_reg;
        mask_next    = mask_reg;
        stat_rd      = 1'b0;
        if (ph_wr_reg) begin
            case (ph_addr_reg)
                `REG_CTRL:     ctrl_next = hwdata[5:0];
                `REG_IRQ_MASK: mask_next = hwdata[3:0];
                default: ;
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            ph_addr_next = haddr[7:0];
            // only whole-word writes land
            ph_wr_next   = hwrite && hsize == 3'h2;
            hrdata_next  = 32'h0;
            if (!hwrite) begin
                case (haddr[7:0])
                    `REG_CTRL:     hrdata_next = {26'h0, ctrl_reg};
                    `REG_STATUS:   hrdata_next = {22'h0, pro_reg, route, unlock,
                                                  preemphasis_flag, detected_rate_code};
                    `REG_IRQ_STAT: begin
                        hrdata_next = {28'h0, stat_reg};
                        stat_rd     = 1'b1;
                    end
                    `REG_IRQ_MASK: hrdata_next = {28'h0, mask_reg};
                    default:       hrdata_next = 32'h0;
                endcase
            end
        end
        // an event in the clearing cycle survives the read
        stat_next = (stat_rd ? 4'h0 : stat_reg) | events;
        irq_next  = |(stat_next & mask_next);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg    <= `CTRL_RESET;
            mask_reg    <= 4'h0;
            stat_reg    <= 4'h0;
            irq         <= 1'b0;
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else if (ce) begin
            ctrl_reg    <= ctrl_next;
            mask_reg    <= mask_next;
            stat_reg    <= stat_next;
            irq         <= irq_next;
            ph_wr_reg   <= ph_wr_next;
            ph_addr_reg <= ph_addr_next;
            hrdata      <= hrdata_next;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end
endmodule

//--- dv/dir_props.sv
// port-level assertions for the clock mode / fs detect block
// assumes ce held high and a single ahb-lite master; bound at the foot
`timescale 1ns/100ps
module dir_props
    import dir_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // receiver side
    input wire logic        preamble_in,
    input wire logic        cs_update,
    input wire cs_block_s   cs_ch1,
    input wire cs_block_s   cs_ch2,
    input wire clk_route_s  route,
    input wire logic        unlock,
    input wire logic [3:0]  detected_rate_code,
    input wire logic        preemphasis_flag
);
    logic [5:0] ctrl_reg, ctrl_next;
    logic       wr_reg, wr_next, pre_reg;
    logic [1:0] age_reg, age_next;
    logic [8:0] gap_reg, gap_next;
    cs_block_s  cs_sel;
    assign cs_sel = ctrl_reg[5] ? cs_ch2 : cs_ch1;
    // shadow of the control word, so routing can be judged from the ports alone
    always_comb begin
        wr_next = hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h00;
        ctrl_next = wr_reg ? hwdata[5:0] : ctrl_reg;
        age_next = wr_reg ? 2'h0 : (age_reg == 2'h3 ? age_reg : age_reg + 2'h1);
        gap_next = (preamble_in && !pre_reg) ? 9'h0 : (gap_reg == 9'h1ff ? gap_reg : gap_reg + 9'h1);
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {ctrl_reg, wr_reg, age_reg, gap_reg, pre_reg} <= '0;
        end else begin
            {ctrl_reg, wr_reg, age_reg, gap_reg, pre_reg} <=
                {ctrl_next, wr_next, age_next, gap_next, preamble_in};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    route_pll_a: assert property (age_reg == 2'h3 && ctrl_reg[1:0] == 2'h0 |-> route == 3'b100)
        else $error("mode 0 routing wrong");
    route_ext_a: assert property (age_reg == 2'h3 && ctrl_reg[1:0] == 2'h1 |-> route == 3'b011 && unlock)
        else $error("mode 1 routing wrong");
    route_auto_a: assert property (age_reg == 2'h3 && ctrl_reg[1:0] == 2'h2 |-> route == {1'b1, unlock, unlock})
        else $error("mode 2 routing does not follow unlock");
    route_monitor_a: assert property (age_reg == 2'h3 && ctrl_reg[1:0] == 2'h3 |-> route == 3'b111)
        else $error("mode 3 routing wrong");
    pll_stop_a: assert property (age_reg == 2'h3 && !route.pll_run |-> ctrl_reg[1:0] == 2'h1)
        else $error("pll stopped outside mode 1");
    gap_unlock_a: assert property (gap_reg > 9'd345 |-> unlock)
        else $error("lock kept without preambles");
    cons_rate_a: assert property (cs_update && ctrl_reg[4:3] == 2'h3 && !cs_sel.byte0[0]
        |=> detected_rate_code == $past(cs_sel.byte3[3:0]))
        else $error("consumer rate not copied");
    cons_pem_a: assert property (cs_update && !cs_sel.byte0[0] |=> preemphasis_flag ==
        $past(cs_sel.byte0[5:3] == 3'b001 && !cs_sel.byte0[1]))
        else $error("consumer pre-emphasis wrong");
    pro_pem_a: assert property (cs_update && cs_sel.byte0[0]
        |=> preemphasis_flag == $past(cs_sel.byte0[4:2] == 3'b011))
        else $error("professional pre-emphasis wrong");
    cover property ($fell(unlock) && ctrl_reg[1:0] == 2'h2);
    cover property (cs_update && cs_sel.byte0[0]);
    cover property (cs_update && ctrl_reg[5]);
endmodule
bind dir_clock_mode_fs_detect dir_props u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .preamble_in(preamble_in), .cs_update(cs_update), .cs_ch1(cs_ch1), .cs_ch2(cs_ch2),
    .route(route), .unlock(unlock), .detected_rate_code(detected_rate_code),
    .preemphasis_flag(preemphasis_flag)
);

//--- dv/biphase_source.sv
// model of the biphase transmitter feeding the receiver, plus the reference tick
// assumes pins are driven just after rising edges of sys_clk
`timescale 1ns/100ps
module biphase_source (
    // clock
    input wire logic       sys_clk,
    // control
    input wire logic       run,
    input wire logic [8:0] period,
    // pins
    output logic           preamble_in,
    output logic           ref_tick_in
);
    logic [8:0] cnt = '0;
    logic [8:0] rcnt = '0;
    initial preamble_in = 1'b0;
    initial ref_tick_in = 1'b0;
    // tick rate unrelated to the frame rate, so the two clocks differ
    always @(posedge sys_clk) begin
        rcnt <= (rcnt == 9'd39) ? 9'd0 : rcnt + 9'd1;
        ref_tick_in <= rcnt < 9'd2;
    end
    // one preamble edge per frame; line idles low with no stream
    always @(posedge sys_clk) begin
        cnt <= (!run || cnt >= period - 9'd1) ? 9'd0 : cnt + 9'd1;
        preamble_in <= run && cnt < 9'd4;
    end
endmodule

//--- dv/dir_clock_mode_fs_detect_test.sv
// self-checking bench for the clock mode / fs detect block
// assumes the biphase_source model and the bound dir_props checker
`timescale 1ns/100ps
`include "dir_defs.svh"
module dir_clock_mode_fs_detect_test;
    import dir_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        cs_update = 1'b0, run = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [8:0]  period = 9'd100;
    logic [3:0]  detected_rate_code;
    logic        hreadyout, hresp, unlock, preemphasis_flag, irq, preamble_in, ref_tick_in;
    cs_block_s   cs_ch1 = '0, cs_ch2 = '0;
    clk_route_s  route;
    int          err_count = 0, n_compared = 0, cyc = 0;
    biphase_source u_src (.sys_clk(sys_clk), .run(run), .period(period),
        .preamble_in(preamble_in), .ref_tick_in(ref_tick_in));
    dir_clock_mode_fs_detect #(.LOCK_QUAL_CYCLES(50)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .preamble_in(preamble_in),
        .ref_tick_in(ref_tick_in), .cs_update(cs_update), .cs_ch1(cs_ch1), .cs_ch2(cs_ch2),
        .route(route), .unlock(unlock), .detected_rate_code(detected_rate_code),
        .preemphasis_flag(preemphasis_flag), .irq(irq));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard: the whole run needs well under 70000 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            err_count++;
            wrap_up;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic wait_unlock(input logic v, input int lim);
        for (int i = 0; i < lim && unlock !== v; i++) @(posedge sys_clk);
        chk("unlock", {31'h0, v}, {31'h0, unlock});
    endtask
    task automatic wait_rate(input logic [3:0] v, input int lim);
        for (int i = 0; i < lim && detected_rate_code !== v; i++) @(posedge sys_clk);
        chk("meter rate", {28'h0, v}, {28'h0, detected_rate_code});
    endtask
    task automatic send(input cs_block_s c1, input cs_block_s c2);
        @(posedge sys_clk);
        {cs_ch1, cs_ch2, cs_update} <= {c1, c2, 1'b1};
        @(posedge sys_clk);
        cs_update <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic t_reset;
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("status", 32'h121, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        bus(1'b1, `REG_STATUS, 32'hfff);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("status ro", 32'h121, rd);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic t_modes;
        logic [2:0] exp [4] = '{3'b100, 3'b011, 3'b111, 3'b111};
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `REG_CTRL, 32'(m));
            repeat (3) @(posedge sys_clk);
            chk("route", {29'h0, exp[m]}, {29'h0, route});
        end
    endtask
    task automatic t_lock;
        bus(1'b1, `REG_IRQ_MASK, 32'h3);
        bus(1'b1, `REG_CTRL, 32'h2);
        run <= 1'b1;
        wait_unlock(1'b0, 3000);
        @(posedge sys_clk);
        chk("auto locked", 32'h4, {29'h0, route});
        chk("irq on lock", 32'h1, {31'h0, irq});
        bus(1'b0, `REG_IRQ_STAT, 32'h0);
        chk("lock event", 32'h2, rd & 32'h3);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        period <= 9'd112;
        wait_unlock(1'b1, 400);
        @(posedge sys_clk);
        chk("auto fallback", 32'h7, {29'h0, route});
        wait_unlock(1'b0, 3000);
        run <= 1'b0;
        wait_unlock(1'b1, 500);
        bus(1'b1, `REG_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk("pll off", 32'h3, {29'h0, route});
    endtask
    task automatic t_cs_rate;
        logic [3:0]  code [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha, 4'hc, 4'he};
        logic [23:0] pro [8] = '{24'h000041, 24'h500041, 24'h000081, 24'h0000c1,
                                 24'h500001, 24'h100001, 24'h580001, 24'h180001};
        bus(1'b1, `REG_CTRL, 32'h18);
        for (int i = 0; i < 8; i++) begin
            send({8'h0, 4'h5, code[i], 8'h0}, '0);
            chk("consumer rate", {28'h0, code[i]}, {28'h0, detected_rate_code});
            send(pro[i], '0);
            chk("pro rate", {28'h0, code[i]}, {28'h0, detected_rate_code});
        end
    endtask
    task automatic t_pem;
        logic [7:0] b0 [8] = '{8'h08, 8'h0c, 8'h18, 8'h0a, 8'h0d, 8'h0f, 8'h1d, 8'h05};
        logic       pe [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 8; i++) begin
            send({16'h0, b0[i]}, '0);
            chk("pem", {31'h0, pe[i]}, {31'h0, preemphasis_flag});
        end
        bus(1'b1, `REG_IRQ_MASK, 32'h0);
        bus(1'b1, `REG_CTRL, 32'h38);
        send('0, 24'h000308);
        chk("pem ch2", 32'h1, {31'h0, preemphasis_flag});
        chk("rate ch2", 32'h3, {28'h0, detected_rate_code});
        bus(1'b0, `REG_IRQ_STAT, 32'h0);
        bus(1'b1, `REG_CTRL, 32'h18);
        send('0, 24'h000308);
        chk("pem ch1", 32'h0, {31'h0, preemphasis_flag});
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `REG_IRQ_MASK, 32'h8);
        repeat (2) @(posedge sys_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        bus(1'b0, `REG_IRQ_STAT, 32'h0);
        chk("pem event", 32'h8, rd & 32'h8);
        repeat (2) @(posedge sys_clk);
        chk("irq read clear", 32'h0, {31'h0, irq});
    endtask
    task automatic t_meter;
        // ticks every 40 cycles stand for 24.576 MHz / 512, so frames every 60 are 32 kHz
        bus(1'b1, `REG_CTRL, 32'h10);
        period <= 9'd60;
        run <= 1'b1;
        wait_unlock(1'b0, 3000);
        wait_rate(`RATE_32K, 22000);
        // same ticks with the ratio bit set stretch the window to 768 ticks, 1.5x as long, so the rate reads 1.5x
        bus(1'b1, `REG_CTRL, 32'h14);
        wait_rate(`RATE_48K, 32000);
        run <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_modes;
        t_lock;
        t_cs_rate;
        t_pem;
        t_meter;
        wrap_up;
    end
endmodule
